// >>> airs_defines.svh
// Constants for the converter input and reference select block.
// Assumes inclusion by bare name from the package; the design files use its macros without including it.
`ifndef AIRS_DEFINES_SVH
`define AIRS_DEFINES_SVH
`define AIRS_ADDR_W 2
`define AIRS_OFF_INCLK 2'h0
`define AIRS_OFF_REF 2'h1
`define AIRS_OFF_PINS 2'h2
`define AIRS_RST_INCLK 8'h00
`define AIRS_RST_REF 8'h00
`define AIRS_RST_PINS 8'hFF
`define AIRS_RST_GAIN 3'h1
`define AIRS_INCLK_MASK 8'hE7
`define AIRS_SEL_HI 7
`define AIRS_SEL_LO 5
`define AIRS_CKS_HI 2
`define AIRS_CKS_LO 0
`define AIRS_BIT_PGA 7
`define AIRS_BIT_BG 6
`define AIRS_BIT_VRI 5
`define AIRS_BIT_VRO 4
`define AIRS_VRS_HI 3
`define AIRS_VRS_LO 0
`define AIRS_DIV_W 7
`define AIRS_NPINS 8
`endif

// >>> airs_pkg.sv
// Types for the converter input and reference select block.
// Assumes airs_defines.svh is on the include path.
`include "airs_defines.svh"
package airs_pkg;
	// Converted-signal source
	typedef enum logic [2:0] {
		AIRS_SIG_EXT = 3'h0,
		AIRS_SIG_VDD = 3'h1,
		AIRS_SIG_VDD2 = 3'h2,
		AIRS_SIG_VDD4 = 3'h3,
		AIRS_SIG_VR = 3'h4,
		AIRS_SIG_VR2 = 3'h5,
		AIRS_SIG_VR4 = 3'h6
	} airs_sig_t;
	// Reference source
	typedef enum logic [1:0] {
		AIRS_REF_VDD = 2'h0,
		AIRS_REF_PIN = 2'h1,
		AIRS_REF_BG = 2'h2
	} airs_ref_t;
	// Register bus request
	typedef struct packed {
		logic [`AIRS_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} airs_bus_t;
	// Converter steering outputs
	typedef struct packed {
		airs_sig_t sig;
		logic ext_connect;
		airs_ref_t ref_src;
		logic [2:0] ref_gain;
		logic pga_on;
		logic bandgap_on;
		logic ref_in_pin;
		logic ref_out_pin;
	} airs_ctl_t;
endpackage

// >>> airs_clkdiv.sv
// Conversion clock divider: free-running counter, one tap per ratio.
// Assumes the select is a registered value in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module airs_clkdiv
	import airs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Ratio select
	input wire logic [2:0] div_sel,
	// Divided clock enable, one cycle in each period
	output logic conv_tick
);
	logic [`AIRS_DIV_W-1:0] cnt_q;
	logic [`AIRS_DIV_W:0] mask;

	// Mask of count bits that must be all ones at the end of a period
	always_comb
	begin
		mask = (`AIRS_DIV_W+1)'(1) << div_sel;
		mask = mask - (`AIRS_DIV_W+1)'(1);
	end

	// Counter runs always; a ratio change takes effect at the next tap
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + `AIRS_DIV_W'(1);
	end

	// Tick when masked bits are all ones; ratio 1 ticks every cycle
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			conv_tick <= 1'b0;
		else
			conv_tick <= ((cnt_q & mask[`AIRS_DIV_W-1:0]) ==
				mask[`AIRS_DIV_W-1:0]);
	end
endmodule
`default_nettype wire

// >>> airs_top.sv
// Converter input, clock and reference selection registers and steering.
// Assumes a single-cycle strobe master on the system clock.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Input select 000 or 100 routes the external channel.
// - Codes 001-011 pick supply fractions, 101-111 reference fractions.
// - Any internal selection disconnects the external channel input.
// - Clock field divides system clock by 1 to 128.
// - Bits 4 and 3 of input/clock register ignore writes, read zero.
// - Each analog pin enable bit makes its pin an analog channel.
// - Gain amplifier enable makes the amplified reference available.
// - Bandgap powered when enabled, off when unused and detectors off.
// - Reference input pin and output pin selects act independently.
// - Reference code table; 1001 reserved; others select supply.
// - Bandgap reference disconnects supply and external pin paths.
// - Analog pin drops other functions, pull-high and direction.
module airs_top
	import airs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port
	input wire airs_bus_t bus,
	output logic [7:0] rdata_q,
	// Detector enables elsewhere that keep the bandgap alive
	input wire logic low_voltage_detect_en,
	input wire logic low_voltage_reset_en,
	// Converter controls
	output airs_ctl_t ctl_q,
	output logic conv_tick_q,
	output logic ref_supply_path_q,
	output logic ref_pin_path_q,
	// Pin steering
	output logic [`AIRS_NPINS-1:0] analog_pin_enable_q,
	output logic [`AIRS_NPINS-1:0] pin_func_off_q,
	output logic [`AIRS_NPINS-1:0] pullhigh_off_q,
	output logic [`AIRS_NPINS-1:0] dir_override_q
);
	logic [7:0] inclk_q;
	logic [7:0] refc_q;
	logic [7:0] pins_q;
	logic [2:0] input_signal_select;
	logic [2:0] conv_clock_divider_select;
	logic [3:0] ref_voltage_select;
	logic ref_gain_amp_enable;
	logic bandgap_ref_enable;
	logic ref_input_pin_select;
	logic ref_output_pin_select;
	logic tick;
	airs_ctl_t ctl_d;

	assign input_signal_select = inclk_q[`AIRS_SEL_HI:`AIRS_SEL_LO];
	assign conv_clock_divider_select = inclk_q[`AIRS_CKS_HI:`AIRS_CKS_LO];
	assign ref_voltage_select = refc_q[`AIRS_VRS_HI:`AIRS_VRS_LO];
	assign ref_gain_amp_enable = refc_q[`AIRS_BIT_PGA];
	assign bandgap_ref_enable = refc_q[`AIRS_BIT_BG];
	assign ref_input_pin_select = refc_q[`AIRS_BIT_VRI];
	assign ref_output_pin_select = refc_q[`AIRS_BIT_VRO];

	// Map input select code to signal source
	function automatic airs_sig_t sig_decode(input logic [2:0] code);
		airs_sig_t s;
		s = AIRS_SIG_EXT;
		unique case (code)
			3'h0, 3'h4: s = AIRS_SIG_EXT;
			3'h1: s = AIRS_SIG_VDD;
			3'h2: s = AIRS_SIG_VDD2;
			3'h3: s = AIRS_SIG_VDD4;
			3'h5: s = AIRS_SIG_VR;
			3'h6: s = AIRS_SIG_VR2;
			3'h7: s = AIRS_SIG_VR4;
		endcase
		return s;
	endfunction

	// Map reference code to source; reserved and unlisted codes use supply
	function automatic airs_ref_t ref_decode(input logic [3:0] code);
		airs_ref_t r;
		case (code)
			4'h1, 4'h2, 4'h3, 4'h4: r = AIRS_REF_PIN;
			4'hA, 4'hB, 4'hC: r = AIRS_REF_BG;
			default: r = AIRS_REF_VDD;
		endcase
		return r;
	endfunction

	// Gain: pin codes 1-4 give x1..x4, bandgap codes A-C give x2..x4
	function automatic logic [2:0] gain_decode(input logic [3:0] code);
		logic [2:0] g;
		case (code)
			4'h1, 4'h2, 4'h3, 4'h4: g = code[2:0] == 3'h4 ? 3'h4 : code[2:0];
			4'hA, 4'hB, 4'hC: g = code[2:0];
			default: g = 3'h1;
		endcase
		return g;
	endfunction

	// Input/clock register; unimplemented bits masked off on write
	// Unused bits held zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			inclk_q <= `AIRS_RST_INCLK;
		else if (bus.wr && bus.addr == `AIRS_OFF_INCLK)
			inclk_q <= bus.wdata & `AIRS_INCLK_MASK;
	end

	// Reference configuration register
	// Stored as written
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			refc_q <= `AIRS_RST_REF;
		else if (bus.wr && bus.addr == `AIRS_OFF_REF)
			refc_q <= bus.wdata;
	end

	// Analog pin enable register, all pins analog after reset
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			pins_q <= `AIRS_RST_PINS;
		else if (bus.wr && bus.addr == `AIRS_OFF_PINS)
			pins_q <= bus.wdata;
	end

	// Read data one cycle after the strobe; unmapped address reads zero
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				`AIRS_OFF_INCLK: rdata_q <= inclk_q;
				`AIRS_OFF_REF: rdata_q <= refc_q;
				`AIRS_OFF_PINS: rdata_q <= pins_q;
				default: rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end

	// Converter steering from register fields
	always_comb
	begin
		ctl_d = '0;
		ctl_d.sig = sig_decode(input_signal_select);
		ctl_d.ext_connect = (ctl_d.sig == AIRS_SIG_EXT);
		ctl_d.ref_src = ref_decode(ref_voltage_select);
		ctl_d.ref_gain = gain_decode(ref_voltage_select);
		ctl_d.pga_on = ref_gain_amp_enable;
		// Bandgap auto-off when nothing needs it
		ctl_d.bandgap_on = bandgap_ref_enable | low_voltage_detect_en |
			low_voltage_reset_en;
		ctl_d.ref_in_pin = ref_input_pin_select;
		ctl_d.ref_out_pin = ref_output_pin_select;
	end

	// Registered steering; takes effect two cycles after the write strobe
	// Reset matches the decode of the reset register values, so the
	// external channel shows as connected from the first cycle
	// One-cycle latency
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			ctl_q <= '{sig: AIRS_SIG_EXT, ext_connect: 1'b1,
				ref_src: AIRS_REF_VDD, ref_gain: `AIRS_RST_GAIN, default: '0};
		else
			ctl_q <= ctl_d;
	end

	// Bandgap reference isolates supply and pin paths
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ref_supply_path_q <= 1'b1;
			ref_pin_path_q <= 1'b0;
		end
		else
		begin
			ref_supply_path_q <= (ctl_d.ref_src == AIRS_REF_VDD);
			ref_pin_path_q <= (ctl_d.ref_src == AIRS_REF_PIN);
		end
	end

	generate
		for (genvar i = 0; i < `AIRS_NPINS; i++)
		begin : g_pin
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					analog_pin_enable_q[i] <= 1'b1;
					pin_func_off_q[i] <= 1'b1;
					pullhigh_off_q[i] <= 1'b1;
					dir_override_q[i] <= 1'b1;
				end
				else
				begin
					analog_pin_enable_q[i] <= pins_q[i];
					pin_func_off_q[i] <= pins_q[i];
					pullhigh_off_q[i] <= pins_q[i];
					dir_override_q[i] <= pins_q[i];
				end
			end
		end
	endgenerate

	airs_clkdiv u_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.div_sel(conv_clock_divider_select),
		.conv_tick(tick)
	);

	// Retime tick so the output leaves a flip-flop of this module
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			conv_tick_q <= 1'b0;
		else
			conv_tick_q <= tick;
	end

	// Checks
	sequence s_write_ref;
		bus.wr && bus.addr == `AIRS_OFF_REF;
	endsequence
	sequence s_write_inclk;
		bus.wr && bus.addr == `AIRS_OFF_INCLK;
	endsequence
	sequence s_read_inclk;
		bus.rd && !bus.wr && bus.addr == `AIRS_OFF_INCLK;
	endsequence
	sequence s_write_pins;
		bus.wr && bus.addr == `AIRS_OFF_PINS;
	endsequence
	sequence s_read_pins;
		bus.rd && !bus.wr && bus.addr == `AIRS_OFF_PINS;
	endsequence

	a_ext_disconnect:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q.ext_connect == (ctl_q.sig == AIRS_SIG_EXT) &&
		ctl_q.ext_connect == ($past(input_signal_select) inside {3'h0, 3'h4}))
	else $error("external channel connect mismatch");

	a_unused_bits_zero:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.rd && bus.addr == `AIRS_OFF_INCLK |=> rdata_q[4:3] == 2'h0)
	else $error("unimplemented bits read nonzero");

	a_ref_readback:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_write_ref ##1 (bus.rd && bus.addr == `AIRS_OFF_REF && !bus.wr)
		|=> rdata_q == $past(bus.wdata, 2))
	else $error("reference register readback wrong");

	a_pga_follows:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_write_ref |=> ##1 ctl_q.pga_on == $past(bus.wdata[7], 2))
	else $error("amplifier enable did not follow write");

	a_bandgap_off:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		!$past(bandgap_ref_enable) && !$past(low_voltage_detect_en) &&
		!$past(low_voltage_reset_en) |-> !ctl_q.bandgap_on)
	else $error("bandgap not switched off");

	a_bg_isolates:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q.ref_src == AIRS_REF_BG |-> !ref_supply_path_q && !ref_pin_path_q)
	else $error("bandgap reference not isolated");

	a_reserved_vdd:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(ref_voltage_select) inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
			4'hD, 4'hE, 4'hF} |-> ctl_q.ref_src == AIRS_REF_VDD)
	else $error("reserved or unlisted code not mapped to supply");

	a_pin_takeover:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		pullhigh_off_q == $past(pins_q) && dir_override_q == $past(pins_q))
	else $error("pin takeover not following enables");

	a_div_one:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		conv_clock_divider_select == 3'h0 [*4] |-> conv_tick_q)
	else $error("divide by one not ticking every cycle");

	a_ext_source:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(input_signal_select) inside {3'h0, 3'h4} |->
		ctl_q.sig == AIRS_SIG_EXT && ctl_q.ext_connect)
	else $error("external code did not route the channel");

	a_int_supply:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(input_signal_select) == 3'h1 |-> ctl_q.sig == AIRS_SIG_VDD)
	else $error("supply code did not select the supply");

	a_int_cuts_ext:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		!($past(input_signal_select) inside {3'h0, 3'h4}) |->
		!ctl_q.ext_connect && ctl_q.sig != AIRS_SIG_EXT)
	else $error("internal source left the channel connected");

	a_div_two:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		conv_clock_divider_select == 3'h1 [*4] ##1 conv_tick_q |=>
		!conv_tick_q)
	else $error("divide by two ticked twice in a row");

	a_inclk_readback:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_write_inclk ##1 s_read_inclk |=>
		rdata_q == ($past(bus.wdata, 2) & `AIRS_INCLK_MASK))
	else $error("input clock register readback wrong");

	a_pins_readback:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_write_pins ##1 s_read_pins |=> rdata_q == $past(bus.wdata, 2))
	else $error("pin enable register readback wrong");

	a_ref_pins:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q.ref_in_pin == $past(ref_input_pin_select) &&
		ctl_q.ref_out_pin == $past(ref_output_pin_select))
	else $error("reference pin selects not following register");

	a_bg_gain:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(ref_voltage_select) == 4'hC |->
		ctl_q.ref_src == AIRS_REF_BG && ctl_q.ref_gain == 3'h4)
	else $error("bandgap times four not decoded");

	a_bandgap_on:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(bandgap_ref_enable) |-> ctl_q.bandgap_on)
	else $error("bandgap off while enabled");

	a_rdata_idle:
	assert property (@(posedge clk_sys) disable iff (!reset_n)
		!bus.rd |=> rdata_q == 8'h00)
	else $error("read data stood outside its cycle");
endmodule
`default_nettype wire

// >>> test_airs_top.sv
// Self-checking bench for the converter input and reference select block.
// Assumes the design files are compiled first; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module test_airs_top
	import airs_pkg::*;
;
	logic clk_sys, reset_n, low_voltage_detect, low_voltage_reset, tick_q, sup_q, pin_q;
	airs_bus_t bus;
	airs_ctl_t ctl_q;
	logic [7:0] rdata_q, ape_q, pfo_q, pho_q, dov_q, v, e;
	int mismatches, n_tests, i, p;
	// Arbitrary settle count in cycles for a freshly enabled bandgap
	localparam int bandgap_settle_time = 4;

	airs_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
		.rdata_q(rdata_q), .low_voltage_detect_en(low_voltage_detect),
		.low_voltage_reset_en(low_voltage_reset), .ctl_q(ctl_q), .conv_tick_q(tick_q),
		.ref_supply_path_q(sup_q), .ref_pin_path_q(pin_q),
		.analog_pin_enable_q(ape_q), .pin_func_off_q(pfo_q),
		.pullhigh_off_q(pho_q), .dir_override_q(dov_q));

	// 10 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Compare and count; four-state compare so an unknown matches only an identical unknown
	task check(input string n, input logic [7:0] seen, input logic [7:0] ex);
		n_tests++;
		if (seen !== ex)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, ex, seen);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One-cycle write, then wait until the controls have settled
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle
	task rdchk(input logic [1:0] a, input logic [7:0] ex, input string n);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		check(n, rdata_q, ex);
	endtask

	// Write then read one register with no gap between the strobes
	task wr_rd(input logic [1:0] a, input logic [7:0] d,
		input logic [7:0] ex, input string n);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		check(n, rdata_q, ex);
	endtask

	// Cycles between two divider pulses, bounded wait
	task tick_gap;
		int k;
		k = 0;
		while (tick_q !== 1'b1)
		begin
			@(posedge clk_sys);
			#1;
			k++;
			if (k > 300)
			begin
				mismatches++;
				tally_and_finish;
			end
		end
		p = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			p++;
		end while (tick_q !== 1'b1 && p < 300);
	endtask

	// Source expected for an input select code
	function logic [2:0] exp_sig(input logic [2:0] c);
		case (c)
			3'h0, 3'h4: return 3'h0;
			3'h5: return 3'h4;
			3'h6: return 3'h5;
			3'h7: return 3'h6;
			default: return c;
		endcase
	endfunction

	// Reference source and gain packed as {src, gain}
	function logic [4:0] exp_ref(input logic [3:0] c);
		case (c)
			4'h1: return {2'h1, 3'h1};
			4'h2, 4'h3, 4'h4: return {2'h1, c[2:0]};
			4'hA, 4'hB, 4'hC: return {2'h2, c[2:0]};
			default: return {2'h0, 3'h1};
		endcase
	endfunction

	// Cut a hang short
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish;
	end

	// Main sequence
	initial
	begin
		bus = '0;
		low_voltage_detect = 1'b0;
		low_voltage_reset = 1'b0;
		reset_n = 1'b0;
		mismatches = 0;
		n_tests = 0;
		void'($urandom(32'h5259558f));
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		check("pins after reset", ape_q, 8'hFF);
		rdchk(2'h0, 8'h00, "input clock reg");
		rdchk(2'h1, 8'h00, "reference reg");
		rdchk(2'h2, 8'hFF, "pin enable reg");
		wr(2'h3, 8'h5A);
		rdchk(2'h3, 8'h00, "unmapped reg");
		$display("reset and map test done");
		// Every input select code, every divider ratio
		for (i = 0; i < 8; i++)
		begin
			v = 8'($urandom);
			v[7:5] = i[2:0];
			v[2:0] = 3'(7 - i);
			wr(2'h0, v);
			check("sig", 8'(ctl_q.sig), 8'(exp_sig(v[7:5])));
			check("ext", 8'(ctl_q.ext_connect), 8'(v[6:5] == 2'h0));
			rdchk(2'h0, v & 8'hE7, "input clock readback");
			tick_gap;
			check("tick gap", 8'(p), 8'(1 << v[2:0]));
		end
		$display("input and divider test done");
		// Every reference code except the reserved one
		for (i = 0; i < 16; i++)
		begin
			if (i == 9)
				continue;
			v = 8'($urandom);
			v[3:0] = i[3:0];
			@(posedge clk_sys);
			{low_voltage_reset, low_voltage_detect} <= 2'($urandom);
			wr(2'h1, v);
			// Let a freshly enabled bandgap settle before use
			if (v[6])
			begin
				repeat (bandgap_settle_time) @(posedge clk_sys);
				#1;
			end
			e = 8'(exp_ref(v[3:0]));
			check("ref src", 8'(ctl_q.ref_src), 8'(e[4:3]));
			check("ref gain", 8'(ctl_q.ref_gain), 8'(e[2:0]));
			check("paths", 8'({sup_q, pin_q}),
				8'({e[4:3] == 2'h0, e[4:3] == 2'h1}));
			check("pga", 8'(ctl_q.pga_on), 8'(v[7]));
			check("bandgap", 8'(ctl_q.bandgap_on), 8'(v[6] | low_voltage_detect | low_voltage_reset));
			check("ref pins", 8'({ctl_q.ref_in_pin, ctl_q.ref_out_pin}),
				8'(v[5:4]));
			rdchk(2'h1, v, "reference readback");
		end
		$display("reference test done");
		// Pin enables: both extremes, then random patterns
		for (i = 0; i < 10; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			wr(2'h2, v);
			check("analog pins", ape_q, v);
			check("func off", pfo_q, v);
			check("pull off", pho_q, v);
			check("dir override", dov_q, v);
			rdchk(2'h2, v, "pin readback");
		end
		$display("pin test done");
		// Back-to-back write and read of every register
		v = 8'($urandom);
		wr_rd(2'h0, v, v & 8'hE7, "input clock back to back");
		wr_rd(2'h1, v, v, "reference back to back");
		wr_rd(2'h2, v, v, "pins back to back");
		$display("back to back test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
